// >>> design/icff_input_capture.sv
// Notes on behaviour
// - With falling-edge capture the bits load the data on each high-to-low capture clock edge.
// - With rising-edge capture the bits load the data on each low-to-high capture clock edge.
// - When the enable is used and low, active edges leave the output unchanged; high lets them load.
// - The loaded value is the data level seen just before the active edge.
// - A clear-type build drives its output low at reset without waiting for a clock edge.
// - A preset-type build drives its output high at reset without waiting for a clock edge.
// - The global set/reset line restores the initial value; active high, optionally inverted.
// - The wide form keeps one independent bit per data lane, sharing one clock and enable.
`timescale 1ns/10ps
module icff_input_capture #(
  parameter bit EDGE_FALLING = 1'b0,
  parameter bit PRESET_INIT = 1'b0,
  parameter bit USE_CE = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icff_pkg::ICFF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pad side
  input wire logic [icff_pkg::ICFF_DATA_W-1:0] input_pad,
  input wire logic capture_clk,
  input wire logic capture_en,
  input wire logic global_set_reset,
  // captured data
  output logic [icff_pkg::ICFF_DATA_W-1:0] capture_q
);
  import icff_pkg::*;

  localparam logic [ICFF_DATA_W-1:0] INIT_VEC = {ICFF_DATA_W{PRESET_INIT}};

  logic [ICFF_DATA_W-1:0] data_s;
  logic clk_s;
  logic ce_s;
  logic gsr_s;
  logic [ICFF_DATA_W-1:0] data_prev_q;
  logic clk_prev_q;
  logic ce_prev_q;
  logic [1:0] warm_q;
  logic prime_q;
  logic edge_rise;
  logic edge_fall;
  logic active_edge;
  logic ce_ok;
  logic gsr_act;
  logic load;
  logic [ICFF_DATA_W-1:0] lane_mask;
  logic [1:0] ctrl_q;
  logic [1:0] width_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [15:0] count_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc_first;
  logic wr_fire;
  logic addr_ok;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: all pins share the same latency so the data stays
  // aligned with the clock it is judged against

  // pads feed the sampler directly, no buffer stage assumed
  // the capture clock may be any toggling source, it is only sampled
  icff_sync #(
    .W(ICFF_PIN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({global_set_reset, capture_en, capture_clk, input_pad}),
    .sync_out({gsr_s, ce_s, clk_s, data_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the sampled capture clock

  // one extra stage holds the levels from just before the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_prev_q <= '0;
      clk_prev_q <= 1'b0;
      ce_prev_q <= 1'b0;
    end else begin
      data_prev_q <= data_s;
      clk_prev_q <= clk_s;
      ce_prev_q <= ce_s;
    end
  end

  // a clock already high at reset release must not read as a rising edge:
  // edges count only once both the synchroniser and the previous stage hold pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_q <= 2'h0;
      prime_q <= 1'b0;
    end else begin
      warm_q <= {warm_q[0], 1'b1};
      prime_q <= warm_q[1];
    end
  end

  assign edge_rise = prime_q & clk_s & ~clk_prev_q;
  assign edge_fall = prime_q & ~clk_s & clk_prev_q;

  // limitation: the capture clock must stay well below half of pclk
  assign active_edge = EDGE_FALLING ? edge_fall : edge_rise;
  assign ce_ok = ~USE_CE | ce_prev_q;

  // an inverter in front of the line makes it active low
  assign gsr_act = (gsr_s ^ ctrl_q[ICFF_CTRL_INVERT_BIT]) | ctrl_q[ICFF_CTRL_FORCE_BIT];
  assign load = active_edge & ce_ok & ~gsr_act;
  assign lane_mask = icff_lane_mask(width_q);

  ////////////////////////////////////////////////////////////////////////////
  // capture lanes: one independent bit per lane, one shared edge and enable

  // lanes outside the selected width rest at the initial value
  for (genvar i = 0; i < ICFF_DATA_W; i++) begin : g_lane
    icff_cell #(
      .INIT(PRESET_INIT)
    ) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .force_init(gsr_act | ~lane_mask[i]),
      .load(load),
      .d(data_prev_q[i]),
      .q(capture_q[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture counter and sticky flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= ICFF_COUNT_RST;
    end else if (load) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // an event in the clearing cycle survives: set wins over clear
  always_comb begin
    flags_d = flags_q;
    if (wr_fire && paddr == ICFF_OFS_FLAGS) begin
      flags_d = flags_q & ~pwdata[1:0];
    end
    if (load) begin
      flags_d[ICFF_FLAG_CAPT_BIT] = 1'b1;
    end
    if (gsr_act) begin
      flags_d[ICFF_FLAG_GSR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= ICFF_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state; reads latch in the first access cycle,
  // writes land on the edge where the master sees pready

  assign acc_first = psel & penable & ~pready_q;
  assign wr_fire = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ICFF_OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
      ICFF_OFS_WIDTH: rd_mux = {30'h0000_0000, width_q};
      ICFF_OFS_DATA: rd_mux = {16'h0000, capture_q};
      ICFF_OFS_COUNT: rd_mux = {16'h0000, count_q};
      ICFF_OFS_FLAGS: rd_mux = {30'h0000_0000, flags_q};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~addr_ok;
      if (acc_first && !pwrite) begin
        prdata_q <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ICFF_CTRL_RST;
      width_q <= ICFF_WIDTH_RST;
    end else if (wr_fire) begin
      if (paddr == ICFF_OFS_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == ICFF_OFS_WIDTH) begin
        width_q <= pwdata[1:0];
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_gsr_forces_init: assert property (
    @(posedge pclk) disable iff (!presetn)
    gsr_act |=> (capture_q == INIT_VEC))
    else $error("set/reset did not restore initial value");

  a_gsr_holds_init: assert property (
    @(posedge pclk) disable iff (!presetn)
    gsr_act [*2] |=> (capture_q == INIT_VEC) && $stable(capture_q))
    else $error("output moved while set/reset held");

  a_ce_low_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (USE_CE && active_edge && !ce_prev_q && !gsr_act && $stable(width_q))
      |=> (capture_q == $past(capture_q)))
    else $error("disabled edge changed output");

  a_rise_loads_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!EDGE_FALLING && prime_q && clk_s && !clk_prev_q && ce_ok && !gsr_act)
      |=> ((capture_q & $past(lane_mask)) == ($past(data_prev_q) & $past(lane_mask))))
    else $error("rising edge did not load data");

  a_fall_loads_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (EDGE_FALLING && prime_q && !clk_s && clk_prev_q && ce_ok && !gsr_act)
      |=> ((capture_q & $past(lane_mask)) == ($past(data_prev_q) & $past(lane_mask))))
    else $error("falling edge did not load data");

  a_pre_edge_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    load ##1 !gsr_act |-> ((capture_q & $past(lane_mask)) == ($past(data_s, 2) & $past(lane_mask))))
    else $error("loaded value not the pre-edge level");

  a_no_edge_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!active_edge && !gsr_act && $stable(width_q)) |=> $stable(capture_q))
    else $error("output changed without an edge");

  a_lane_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (capture_q & ~$past(lane_mask)) == (INIT_VEC & ~$past(lane_mask)))
    else $error("lane outside width left initial value");

  a_ce_high_loads: assert property (
    @(posedge pclk) disable iff (!presetn)
    (USE_CE && active_edge && ce_prev_q && !gsr_act)
      |=> ((capture_q & $past(lane_mask)) == ($past(data_prev_q) & $past(lane_mask))))
    else $error("enabled edge did not load data");

  a_gsr_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    gsr_act |=> flags_q[ICFF_FLAG_GSR_BIT])
    else $error("set/reset flag not raised");

  a_capt_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    load |=> flags_q[ICFF_FLAG_CAPT_BIT])
    else $error("capture flag not raised");

  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    load |=> (count_q == $past(count_q) + 16'h0001))
    else $error("capture count did not advance");

  a_count_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !load |=> $stable(count_q))
    else $error("capture count moved without a load");

  a_slverr_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error answer without ready");

  a_pready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not a single cycle");

endmodule : icff_input_capture

// >>> design/icff_pkg.sv
package icff_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ICFF_DATA_W = 16;
  localparam int ICFF_ADDR_W = 8;
  localparam int ICFF_PIN_W = ICFF_DATA_W + 3;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ICFF_ADDR_W-1:0] ICFF_OFS_CTRL = 8'h00;
  localparam logic [ICFF_ADDR_W-1:0] ICFF_OFS_WIDTH = 8'h04;
  localparam logic [ICFF_ADDR_W-1:0] ICFF_OFS_DATA = 8'h08;
  localparam logic [ICFF_ADDR_W-1:0] ICFF_OFS_COUNT = 8'h0c;
  localparam logic [ICFF_ADDR_W-1:0] ICFF_OFS_FLAGS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ICFF_CTRL_FORCE_BIT = 0;
  localparam int ICFF_CTRL_INVERT_BIT = 1;
  localparam int ICFF_FLAG_CAPT_BIT = 0;
  localparam int ICFF_FLAG_GSR_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // width codes and reset values
  localparam logic [1:0] ICFF_WIDTH_1 = 2'h0;
  localparam logic [1:0] ICFF_WIDTH_4 = 2'h1;
  localparam logic [1:0] ICFF_WIDTH_8 = 2'h2;
  localparam logic [1:0] ICFF_WIDTH_16 = 2'h3;
  localparam logic [1:0] ICFF_CTRL_RST = 2'h0;
  localparam logic [1:0] ICFF_WIDTH_RST = 2'h3;
  localparam logic [1:0] ICFF_FLAGS_RST = 2'h0;
  localparam logic [15:0] ICFF_COUNT_RST = 16'h0000;
  localparam logic ICFF_SYNC_RST = 1'b0;

  function automatic logic [ICFF_DATA_W-1:0] icff_lane_mask(input logic [1:0] code);
    logic [ICFF_DATA_W-1:0] m;
    m = 16'h0001;
    case (code)
      ICFF_WIDTH_1: m = 16'h0001;
      ICFF_WIDTH_4: m = 16'h000f;
      ICFF_WIDTH_8: m = 16'h00ff;
      ICFF_WIDTH_16: m = 16'hffff;
      default: m = 16'h0001;
    endcase
    return m;
  endfunction : icff_lane_mask

endpackage : icff_pkg

// >>> design/icff_sync.sv
`timescale 1ns/10ps
module icff_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import icff_pkg::*;

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{ICFF_SYNC_RST}};
      sync_out <= {W{ICFF_SYNC_RST}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : icff_sync

// >>> design/icff_cell.sv
`timescale 1ns/10ps
module icff_cell #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic force_init,
  input wire logic load,
  input wire logic d,
  // captured bit
  output logic q
);
  import icff_pkg::*;

  // power-up value taken without any clock edge
  // a forced initial value outranks any load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= INIT;
    end else if (force_init) begin
      q <= INIT;
    end else if (load) begin
      q <= d;
    end
  end

endmodule : icff_cell

// >>> sim/icff_pad_model.sv
`timescale 1ns/10ps
module icff_pad_model (
  // clock
  input wire logic pclk,
  // pad side
  output logic [icff_pkg::ICFF_DATA_W-1:0] input_pad,
  output logic capture_clk,
  output logic capture_en,
  output logic global_set_reset
);
  import icff_pkg::*;

  initial begin
    input_pad = 16'h0000;
    capture_clk = 1'b0;
    capture_en = 1'b0;
    global_set_reset = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame: data settles 3 periods ahead, clock high 3 and low 6 periods
  task automatic pulse(input logic [ICFF_DATA_W-1:0] d, input logic en);
    @(posedge pclk);
    input_pad <= d; // pad drives the data pin directly
    capture_en <= en;
    repeat (3) @(posedge pclk);
    capture_clk <= 1'b1; // capture clock from its own pin
    repeat (3) @(posedge pclk);
    capture_clk <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse

  // the pin goes through a synchroniser, so give it time to land
  task automatic set_gsr(input logic v);
    @(posedge pclk);
    global_set_reset <= v;
    repeat (4) @(posedge pclk);
  endtask : set_gsr
endmodule : icff_pad_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import icff_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ICFF_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [ICFF_DATA_W-1:0] input_pad, q, q2, q3;
  logic capture_clk, capture_en, global_set_reset;
  logic [15:0] masks [4] = '{16'h0001, 16'h000f, 16'h00ff, 16'hffff};
  logic [1:0] ctl [3] = '{2'h1, 2'h2, 2'h0};
  logic pin [3] = '{1'b0, 1'b0, 1'b1};
  int failures = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  icff_input_capture u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_pad(input_pad), .capture_clk(capture_clk),
    .capture_en(capture_en), .global_set_reset(global_set_reset), .capture_q(q));

  // second build: falling edge, preset; shares the bus, its answers unused
  icff_input_capture #(.EDGE_FALLING(1'b1), .PRESET_INIT(1'b1)) u_dut_fall (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .input_pad(input_pad),
    .capture_clk(capture_clk), .capture_en(capture_en),
    .global_set_reset(global_set_reset), .capture_q(q2));

  // third build: enable ignored, so a disabled pulse still loads
  icff_input_capture #(.USE_CE(1'b0)) u_dut_nce (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .input_pad(input_pad), .capture_clk(capture_clk),
    .capture_en(capture_en), .global_set_reset(global_set_reset), .capture_q(q3));

  icff_pad_model u_pad (.pclk(pclk), .input_pad(input_pad), .capture_clk(capture_clk),
    .capture_en(capture_en), .global_set_reset(global_set_reset));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        finish_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rchk

  task automatic cap(input logic [15:0] d, input logic en, input logic [15:0] e1, e2);
    u_pad.pulse(d, en);
    chk("capture_q", {16'h0, q}, {16'h0, e1});
    chk("capture_q_fall", {16'h0, q2}, {16'h0, e2});
  endtask : cap

  // lanes above the selected width stay at the power-up value
  function automatic logic [15:0] mix(input logic [15:0] d, m, input logic init);
    return (d & m) | ({16{init}} & ~m);
  endfunction : mix

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    chk("q_reset", {16'h0, q}, 32'h0);
    chk("q_fall_reset", {16'h0, q2}, 32'hffff);
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk("width_rst", ICFF_OFS_WIDTH, 32'h3);
    rchk("count_rst", ICFF_OFS_COUNT, 32'h0);
    $display("test reset done");
    cap(16'ha5c3, 1'b1, 16'ha5c3, 16'ha5c3);
    rchk("data", ICFF_OFS_DATA, 32'ha5c3);
    cap(16'h1234, 1'b0, 16'ha5c3, 16'ha5c3);
    chk("capture_q_nce", {16'h0, q3}, 32'h1234);
    rchk("count", ICFF_OFS_COUNT, 32'h1);
    $display("test capture done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ICFF_OFS_WIDTH, 32'(i));
      rchk("width", ICFF_OFS_WIDTH, 32'(i));
      cap(16'h6b9d ^ 16'(i), 1'b1, mix(16'h6b9d ^ 16'(i), masks[i], 1'b0),
        mix(16'h6b9d ^ 16'(i), masks[i], 1'b1));
    end
    $display("test width done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ICFF_OFS_CTRL, {30'h0, ctl[i]});
      u_pad.set_gsr(pin[i]);
      cap(16'h0ff0, 1'b1, 16'h0000, 16'hffff);
      apb(1'b1, ICFF_OFS_CTRL, 32'h0);
      u_pad.set_gsr(1'b0);
      cap(16'hc33c, 1'b1, 16'hc33c, 16'hc33c);
    end
    rchk("flags", ICFF_OFS_FLAGS, 32'h3);
    apb(1'b1, ICFF_OFS_FLAGS, 32'h3);
    rchk("flags_clr", ICFF_OFS_FLAGS, 32'h0);
    $display("test set_reset done");
    apb(1'b1, 8'h14, 32'h1);
    chk("err_wr", {31'h0, err}, 32'h1);
    apb(1'b1, ICFF_OFS_DATA, 32'h0);
    chk("err_ro", {31'h0, err}, 32'h0);
    rchk("data_ro", ICFF_OFS_DATA, 32'hc33c);
    rchk("unmapped", 8'h14, 32'h0);
    chk("err_rd", {31'h0, err}, 32'h1);
    $display("test bus done");
    finish_test();
  end
endmodule : tb_top
